// file: lwd_consts.svh
// register map, field positions, reset values and timing counts for the watchdog
`ifndef LWD_CONSTS_SVH
`define LWD_CONSTS_SVH

// ============================================================
// register byte offsets
`define LWD_OFS_LOAD    6'h00
`define LWD_OFS_COUNT   6'h04
`define LWD_OFS_CTRL    6'h08
`define LWD_OFS_SERVICE 6'h0c
`define LWD_OFS_STATUS  6'h18
`define LWD_OFS_EVENT   6'h1c
`define LWD_OFS_MASK    6'h20

// ============================================================
// control field positions
`define LWD_CTRL_RSVD_BIT 7
`define LWD_CTRL_MODE_BIT 6
`define LWD_CTRL_EN_BIT   5
`define LWD_CTRL_PRE_MSB  3
`define LWD_CTRL_PRE_LSB  2
`define LWD_CTRL_IRQ_BIT  1

// status and event field positions
`define LWD_STAT_IRQ_BIT  0
`define LWD_STAT_LOCK_BIT 4
`define LWD_EVT_EXPIRE    0
`define LWD_EVT_LOCK      1

// ============================================================
// reset values
`define LWD_RST_LOAD  16'h1000
`define LWD_RST_COUNT 16'h1000
`define LWD_RST_CTRL  16'h00e9
`define LWD_FREE_TOP  16'h1000

// ============================================================
// timing: system clock and low-frequency oscillator rates in hertz
`define LWD_SYS_HZ      50000000
`define LWD_LOW_FREQ_OSC_HZ    32768
`define LWD_LOW_FREQ_OSC_DIV   (`LWD_SYS_HZ / `LWD_LOW_FREQ_OSC_HZ)
`define LWD_IRQ_PULSE   2'h2

`endif

// file: lwd_pkg.sv
// shared types of the lockable watchdog
package lwd_pkg;
  typedef logic [15:0] lwd_word_t;
  typedef logic [1:0]  lwd_pre_sel_t;
  typedef logic [1:0]  lwd_evt_t;
endpackage : lwd_pkg

// file: lwd_low_freq_osc_tick.sv
// low-frequency oscillator tick derived from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "lwd_consts.svh"
module lwd_low_freq_osc_tick
  import lwd_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  output logic      o_tick
);
  localparam int unsigned DIV = `LWD_LOW_FREQ_OSC_DIV;
  logic [10:0] div_reg;

  // ============================================================
  // free-running divider, never gated so the oscillator always runs
  // fractional rate error is accepted; it stays far below oscillator tolerance
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      div_reg <= 11'h000;
      o_tick  <= 1'b0;
    end else if (div_reg == 11'(DIV - 1)) begin
      div_reg <= 11'h000;
      o_tick  <= 1'b1;
    end else begin
      div_reg <= div_reg + 11'h001;
      o_tick  <= 1'b0;
    end
  end
endmodule : lwd_low_freq_osc_tick
`default_nettype wire

// file: lwd_prescaler.sv
// selectable prescaler dividing oscillator ticks by 1, 16, 256 or 4096
`timescale 1ns/1ps
`default_nettype none
module lwd_prescaler
  import lwd_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic         i_tick,
  input  wire logic         i_clear,
  input  wire lwd_pre_sel_t i_sel,
  output logic              o_tick
);
  logic [11:0] pre_reg;
  logic [11:0] last;

  // terminal count for each division factor
  always_comb begin
    case (i_sel)
      2'h0:    last = 12'h000;
      2'h1:    last = 12'h00f;
      2'h2:    last = 12'h0ff;
      default: last = 12'hfff;
    endcase
  end

  // ============================================================
  // count oscillator ticks; clear restarts a full period
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_clear) begin
      pre_reg <= 12'h000;
      o_tick  <= 1'b0;
    end else if (i_tick && pre_reg >= last) begin
      pre_reg <= 12'h000;
      o_tick  <= 1'b1;
    end else begin
      if (i_tick) begin
        pre_reg <= pre_reg + 12'h001;
      end
      o_tick <= 1'b0;
    end
  end
endmodule : lwd_prescaler
`default_nettype wire

// file: lwd_watchdog.sv
// lockable 16-bit watchdog with avalon-mm register slave
//
// Behaviour
// - sixteen-bit counter counts down toward zero
// - counter clocked from free-running 32.768 kHz tick
// - prescaler divides by 1, 16, 256, 4096
// - expiry while enabled forces device reset
// - debug option: expiry raises interrupt instead
// - enabled and counting after every reset
// - setting enable write-protects control and load
// - one disable and re-enable, then locked
// - status bit 4 shows lock
// - only device reset clears lock; an unlocked control write can also clear enable
// - load writable until a control write sets enable
// - clearing enable stops; settings then changeable
// - interrupt flag is two-cycle pulse
// - control bit 6 selects periodic or free
// - free-running mode wraps at 0x1000
`timescale 1ns/1ps
`default_nettype none
`include "lwd_consts.svh"
module lwd_watchdog
  import lwd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_irq,
  output logic             o_wdog_reset_req
);
  // ============================================================
  // declarations
  lwd_word_t  load_reg;
  lwd_word_t  count_reg;
  lwd_word_t  ctrl_reg;
  lwd_word_t  wmask;
  lwd_word_t  wdata;
  lwd_word_t  ctrl_next;
  lwd_evt_t   evt_reg;
  lwd_evt_t   mask_reg;
  lwd_evt_t   evt_next;
  logic       lock_reg;
  logic       ack_reg;
  logic [1:0] irq_cnt_reg;
  logic       irq_flag;
  logic       wr_acc;
  logic       rd_acc;
  logic       ctrl_wr;
  logic       load_wr;
  logic       srv_wr;
  logic       enabled;
  logic       periodic;
  logic       irq_mode;
  logic       osc_tick;
  logic       cnt_tick;
  logic       expire;
  logic       lock_now;

  // ============================================================
  // avalon slave: one wait cycle, then the access completes
  // the single wait state lets read data come from a flip-flop
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_acc = i_avs_write & ack_reg;
  assign rd_acc = i_avs_read & ack_reg;
  assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wdata = i_avs_writedata[15:0];

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  // decoded accepted writes
  // control and load writes ignored once locked
  assign ctrl_wr = wr_acc && i_avs_address == `LWD_OFS_CTRL && !lock_reg;
  assign load_wr = wr_acc && i_avs_address == `LWD_OFS_LOAD && !lock_reg;
  assign srv_wr  = wr_acc && i_avs_address == `LWD_OFS_SERVICE;
  assign ctrl_next = (ctrl_reg & ~wmask) | (wdata & wmask);

  // ============================================================
  // control fields
  assign enabled  = ctrl_reg[`LWD_CTRL_EN_BIT];
  assign periodic = ctrl_reg[`LWD_CTRL_MODE_BIT];
  assign irq_mode = ctrl_reg[`LWD_CTRL_IRQ_BIT];
  assign lock_now = ctrl_wr && ctrl_next[`LWD_CTRL_EN_BIT];

  // control register; reserved bit 7 reads one, upper bits zero
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_reg <= `LWD_RST_CTRL;
    end else if (ctrl_wr) begin
      // unlocked writes may disable or reconfigure
      ctrl_reg <= {8'h00, 1'b1, ctrl_next[6:0]};
    end
  end

  // lock: the first write that sets enable seals the configuration
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      lock_reg <= 1'b0;
    end else if (lock_now) begin
      lock_reg <= 1'b1;
    end
  end

  // load register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      load_reg <= `LWD_RST_LOAD;
    end else if (load_wr) begin
      load_reg <= (load_reg & ~wmask) | (wdata & wmask);
    end
  end

  // ============================================================
  // clock chain: oscillator tick then prescaler
  // oscillator tick runs whenever not in reset
  lwd_low_freq_osc_tick u_osc (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .o_tick    (osc_tick)
  );

  lwd_prescaler u_pre (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (osc_tick),
    .i_clear   (ctrl_wr | srv_wr),
    .i_sel     (ctrl_reg[`LWD_CTRL_PRE_MSB:`LWD_CTRL_PRE_LSB]),
    .o_tick    (cnt_tick)
  );

  // ============================================================
  // down counter
  assign expire = enabled && cnt_tick && count_reg == 16'h0000;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      count_reg <= `LWD_RST_COUNT;
    end else if (ctrl_wr) begin
      count_reg <= ctrl_next[`LWD_CTRL_MODE_BIT] ? load_reg : `LWD_FREE_TOP;
    end else if (srv_wr) begin
      count_reg <= periodic ? load_reg : `LWD_FREE_TOP;
    end else if (expire) begin
      count_reg <= periodic ? load_reg : `LWD_FREE_TOP;
    end else if (enabled && cnt_tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // ============================================================
  // expiry outcomes
  // reset request holds until the device reset arrives
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_wdog_reset_req <= 1'b0;
    end else if (expire && !irq_mode) begin
      o_wdog_reset_req <= 1'b1;
    end
  end

  // two-cycle interrupt flag; software cannot poll it reliably
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_cnt_reg <= 2'h0;
    end else if (expire && irq_mode) begin
      irq_cnt_reg <= `LWD_IRQ_PULSE;
    end else if (irq_cnt_reg != 2'h0) begin
      irq_cnt_reg <= irq_cnt_reg - 2'h1;
    end
  end
  assign irq_flag = irq_cnt_reg != 2'h0;

  // ============================================================
  // sticky events: set beats a clear in the same cycle
  always_comb begin
    evt_next = evt_reg;
    if (rd_acc && i_avs_address == `LWD_OFS_EVENT) begin
      evt_next = 2'h0;
    end
    if (srv_wr) begin
      evt_next[`LWD_EVT_EXPIRE] = 1'b0;
    end
    if (expire) begin
      evt_next[`LWD_EVT_EXPIRE] = 1'b1;
    end
    if (lock_now) begin
      evt_next[`LWD_EVT_LOCK] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      evt_reg <= 2'h0;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mask_reg <= 2'h0;
    end else if (wr_acc && i_avs_address == `LWD_OFS_MASK && i_avs_byteenable[0]) begin
      mask_reg <= i_avs_writedata[1:0];
    end
  end

  // level interrupt while any unmasked event stands
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_next & mask_reg);
    end
  end

  // ============================================================
  // read data, captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_reg) begin
      case (i_avs_address)
        `LWD_OFS_LOAD:  o_avs_readdata <= {16'h0000, load_reg};
        `LWD_OFS_COUNT: o_avs_readdata <= {16'h0000, count_reg};
        `LWD_OFS_CTRL:  o_avs_readdata <= {16'h0000, ctrl_reg};
        `LWD_OFS_STATUS: o_avs_readdata <= {27'h0, lock_reg, 3'h0, irq_flag};
        // next value: an event landing on the capture edge must not be cleared unseen
        `LWD_OFS_EVENT: o_avs_readdata <= {30'h0, evt_next};
        `LWD_OFS_MASK:  o_avs_readdata <= {30'h0, mask_reg};
        default:        o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  sequence s_irq_two;
    irq_flag [*2] ##1 !irq_flag;
  endsequence

  sequence s_expire_irq;
    expire && irq_mode;
  endsequence

  a_count_down_step: assert property (
    enabled && cnt_tick && count_reg != 16'h0000 && !ctrl_wr && !srv_wr
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not step down by one");

  a_prescale_spacing: assert property (
    cnt_tick |=> !cnt_tick)
    else $error("prescaler ticks back to back");

  a_expiry_reset: assert property (
    expire && !irq_mode |=> o_wdog_reset_req)
    else $error("expiry did not request device reset");

  a_irq_pulse_shape: assert property (
    s_expire_irq |=> s_irq_two)
    else $error("interrupt flag not a two-cycle pulse");

  a_irq_no_reset: assert property (
    (s_expire_irq and !o_wdog_reset_req) |=> !o_wdog_reset_req)
    else $error("interrupt mode still requested reset");

  a_lock_ctrl_held: assert property (
    lock_reg |=> $stable(ctrl_reg) && $stable(load_reg))
    else $error("locked configuration changed");

  a_lock_sticks: assert property (
    lock_reg |=> lock_reg)
    else $error("lock released without reset");

  a_lock_status_read: assert property (
    i_avs_read && !ack_reg && i_avs_address == `LWD_OFS_STATUS
    |=> o_avs_readdata[`LWD_STAT_LOCK_BIT] == $past(lock_reg))
    else $error("status lock bit wrong");

  a_free_wrap_top: assert property (
    expire && !periodic && !ctrl_wr && !srv_wr |=> count_reg == `LWD_FREE_TOP)
    else $error("free-running wrap value wrong");

  a_service_reload: assert property (
    srv_wr && periodic && !ctrl_wr |=> count_reg == $past(load_reg))
    else $error("service did not reload counter");

  a_disabled_holds: assert property (
    !enabled && !ctrl_wr && !srv_wr |=> $stable(count_reg))
    else $error("disabled counter moved");

endmodule : lwd_watchdog
`default_nettype wire

// file: tb_lwd_watchdog.sv
// self-checking testbench of the lockable watchdog
`timescale 1ns/1ps
`default_nettype none
`include "lwd_consts.svh"
module tb_lwd_watchdog
  import lwd_pkg::*;
;
  // ============================================================
  // stimulus and observed signals
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic [5:0]  addr    = 6'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic        rreq;
  logic [31:0] q;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  lwd_watchdog DUT (
    .i_clk_sys         (clk_sys),
    .i_srst            (srst),
    .i_avs_address     (addr),
    .i_avs_read        (rd),
    .i_avs_write       (wr),
    .i_avs_writedata   (wdata),
    .i_avs_byteenable  (4'h3),
    .o_avs_readdata    (rdata),
    .o_avs_waitrequest (wreq),
    .o_irq             (irq),
    .o_wdog_reset_req  (rreq)
  );

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // hang guard: the longest run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      stop_test();
    end
  end

  // ============================================================
  // tasks
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    // the rising edge that sees waitrequest low completes the access
    while (wreq !== 1'b0) @(posedge clk_sys);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(q, exp);
  endtask : rd_chk

  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset

  // bounded wait for the interrupt (sel 0) or the reset request (sel 1)
  task automatic wait_out(input logic sel, input int lim);
    int n;
    n = 0;
    while ((sel ? rreq : irq) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_out

  // ============================================================
  // scenarios
  task automatic test_reset();
    rd_chk(`LWD_OFS_LOAD, 32'h1000);
    rd_chk(`LWD_OFS_COUNT, 32'h1000);
    rd_chk(`LWD_OFS_CTRL, 32'he9);
    rd_chk(`LWD_OFS_STATUS, 32'h0);
    rd_chk(`LWD_OFS_MASK, 32'h0);
    rd_chk(6'h3c, 32'h0);
    chk_bit(rreq, 1'b0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_disable();
    logic [31:0] c1;
    bus(1'b1, `LWD_OFS_CTRL, 32'h0);
    rd_chk(`LWD_OFS_CTRL, 32'h80);
    rd_chk(`LWD_OFS_STATUS, 32'h0);
    bus(1'b0, `LWD_OFS_COUNT, 32'h0);
    c1 = q;
    repeat (2000) @(posedge clk_sys);
    rd_chk(`LWD_OFS_COUNT, c1);
    bus(1'b1, `LWD_OFS_LOAD, 32'h3);
    rd_chk(`LWD_OFS_LOAD, 32'h3);
    $display("test disable done");
  endtask : test_disable

  // periodic, interrupt mode, divide by 1, load 3; then locked
  task automatic test_irq();
    bus(1'b1, `LWD_OFS_CTRL, 32'h62);
    rd_chk(`LWD_OFS_CTRL, 32'he2);
    rd_chk(`LWD_OFS_STATUS, 32'h10);
    rd_chk(`LWD_OFS_COUNT, 32'h3);
    rd_chk(`LWD_OFS_EVENT, 32'h2);
    bus(1'b1, `LWD_OFS_LOAD, 32'h40);
    rd_chk(`LWD_OFS_LOAD, 32'h3);
    bus(1'b1, `LWD_OFS_CTRL, 32'h0);
    rd_chk(`LWD_OFS_CTRL, 32'he2);
    repeat (1600) @(posedge clk_sys);
    bus(1'b0, `LWD_OFS_COUNT, 32'h0);
    chk_bit(q[15:0] < 16'h3, 1'b1);
    bus(1'b1, `LWD_OFS_MASK, 32'h1);
    wait_out(1'b0, 7000);
    chk_bit(irq, 1'b1);
    bus(1'b0, `LWD_OFS_EVENT, 32'h0);
    chk_bit(q[0], 1'b1);
    repeat (3) @(posedge clk_sys);
    chk_bit(irq, 1'b0);
    // the two-cycle flag is long gone by now; only the lock bit remains
    rd_chk(`LWD_OFS_STATUS, 32'h10);
    wait_out(1'b0, 7000);
    chk_bit(irq, 1'b1);
    bus(1'b1, `LWD_OFS_SERVICE, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk_bit(irq, 1'b0);
    chk_bit(rreq, 1'b0);
    $display("test interrupt mode done");
  endtask : test_irq

  // reset mode: serviced in time holds off, then expiry requests reset
  task automatic test_rst_mode();
    do_reset();
    bus(1'b1, `LWD_OFS_LOAD, 32'h2);
    bus(1'b1, `LWD_OFS_CTRL, 32'h60);
    rd_chk(`LWD_OFS_CTRL, 32'he0);
    repeat (4) begin
      repeat (2000) @(posedge clk_sys);
      bus(1'b1, `LWD_OFS_SERVICE, 32'h0);
      chk_bit(rreq, 1'b0);
    end
    wait_out(1'b1, 5000);
    chk_bit(rreq, 1'b1);
    do_reset();
    chk_bit(rreq, 1'b0);
    rd_chk(`LWD_OFS_STATUS, 32'h0);
    rd_chk(`LWD_OFS_CTRL, 32'he9);
    $display("test reset mode done");
  endtask : test_rst_mode

  // free-running from the wrap value, ignoring the load value; divide by 16
  task automatic test_free();
    bus(1'b1, `LWD_OFS_LOAD, 32'h5);
    bus(1'b1, `LWD_OFS_CTRL, 32'h24);
    rd_chk(`LWD_OFS_COUNT, 32'h1000);
    rd_chk(`LWD_OFS_CTRL, 32'ha4);
    // one step needs 16 oscillator ticks, at most about 24400 cycles
    repeat (12000) @(posedge clk_sys);
    rd_chk(`LWD_OFS_COUNT, 32'h1000);
    repeat (14000) @(posedge clk_sys);
    rd_chk(`LWD_OFS_COUNT, 32'h0fff);
    $display("test free-running done");
  endtask : test_free

  // ============================================================
  // main sequence
  initial begin
    do_reset();
    test_reset();
    test_disable();
    test_irq();
    test_rst_mode();
    test_free();
    stop_test();
  end
endmodule : tb_lwd_watchdog
`default_nettype wire
